// [core/gpio_pin_sync.sv]
// two-flop input synchroniser with edge detection for one port
`timescale 1ns/1ps
module gpio_pin_sync (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic [7:0] pin_i,
  output logic      [7:0] level_o,
  output logic      [7:0] rise_o,
  output logic      [7:0] fall_o
);
  logic [7:0] meta_ff;
  logic [7:0] sync_ff;
  logic [7:0] prev_ff;

  // meta_ff is read only by sync_ff; reset loads the pin level into the whole chain
  // so that a pulled-up pin raises no false edge once reset lets go
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_ff <= pin_i;
      sync_ff <= pin_i;
      prev_ff <= pin_i;
    end else begin
      meta_ff <= pin_i; // R14
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~prev_ff;
  assign fall_o  = ~sync_ff & prev_ff;
endmodule

// [core/gpio_pkg.sv]
// package: port geometry, subregister selects, reset values, alternate pin map
package gpio_pkg;
  localparam int PORT_COUNT = 8;
  localparam int PORT_W     = 8;
  localparam int PORT_H_W   = 4;
  localparam int PORT_A     = 0;
  localparam int PORT_C     = 2;
  localparam int PORT_D     = 3;
  localparam int PORT_H     = 7;
  localparam int ALT_LAST   = 3;
  localparam int EDGE_FIRST = 0;
  localparam int EDGE_COUNT = 8;
  localparam int BOTH_FIRST = 8;
  localparam int BOTH_COUNT = 8;

  localparam logic [7:0] SEL_NONE  = 8'h00;
  localparam logic [7:0] SEL_DIR   = 8'h01;
  localparam logic [7:0] SEL_ALT   = 8'h02;
  localparam logic [7:0] SEL_ODRN  = 8'h03;
  localparam logic [7:0] SEL_HDRV  = 8'h04;
  localparam logic [7:0] SEL_STOPR = 8'h05;

  localparam logic [7:0] RST_SEL  = 8'h00;
  localparam logic [7:0] RST_DIR  = 8'hff;
  localparam logic [7:0] RST_ZERO = 8'h00;

  localparam int BIT_I2C_CLK = 6;
  localparam int BIT_I2C_DAT = 7;
  localparam int BIT_PD_NONE = 2;

  typedef enum logic [5:0] {
    SUB_NONE  = 6'b000001,
    SUB_DIR   = 6'b000010,
    SUB_ALT   = 6'b000100,
    SUB_ODRN  = 6'b001000,
    SUB_HDRV  = 6'b010000,
    SUB_STOPR = 6'b100000
  } subreg_t;
endpackage

// [core/gpio_ports.sv]
// gpio ports a-h with subregister control, alternate mux and pin edge events
// Summary of operation
// R1 - seven 8-bit ports plus 4-bit port h
// R2 - per-pin direction, open-drain, drive, alternate select
// R3 - each pin configured independently
// R4 - alternate setting picks gpio or peripheral
// R5 - peripheral owns direction in alternate mode
// R6 - i2c pins a6/a7 forced open-drain
// R7 - port a alternate: timer0, serial0
// R8 - port c alternate: timer1, spi, timer2
// R9 - port d alternate: timer3, serial1, watchdog osc
// R10 - some pins interrupt on selected edge
// R11 - other pins interrupt on both edges
// R12 - direction 0 drives out, 1 tri-states
// R13 - select 01h-05h reach subregisters, others nothing
// R14 - pin inputs synchronised before use
`timescale 1ns/1ps
module gpio_ports (
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  input  wire logic [7:0]          port_sel_i,
  input  wire logic                sel_we_i,
  input  wire logic [7:0]          sel_wdata_i,
  output logic      [7:0]          sel_rdata_o,
  input  wire logic                ctl_we_i,
  input  wire logic [7:0]          ctl_wdata_i,
  output logic      [7:0]          ctl_rdata_o,
  input  wire logic                out_we_i,
  input  wire logic [7:0]          out_wdata_i,
  output logic      [7:0]          out_rdata_o,
  output logic      [7:0]          in_rdata_o,
  input  wire logic [63:0]         pin_in_i,
  output logic      [63:0]         pin_out_o,
  output logic      [63:0]         pin_oe_o,
  output logic      [63:0]         pin_high_drive_o,
  output logic      [63:0]         stop_recover_en_o,
  input  wire logic [7:0]          edge_rise_sel_i,
  output logic      [15:0]         pin_irq_o,
  input  wire logic [63:0]         periph_out_i,
  input  wire logic [63:0]         periph_oe_i,
  output logic      [63:0]         periph_in_o,
  output logic      [7:0]          timer_in_alt_o,
  input  wire logic                timer0_out_alt_i,
  input  wire logic                timer1_out_alt_i,
  input  wire logic                timer2_out_alt_i,
  input  wire logic                timer3_out_alt_i
);
  logic [7:0] sel_ff  [gpio_pkg::PORT_COUNT];
  logic [7:0] dir_ff  [gpio_pkg::PORT_COUNT];
  logic [7:0] alt_ff  [gpio_pkg::PORT_COUNT];
  logic [7:0] odrn_ff [gpio_pkg::PORT_COUNT];
  logic [7:0] hdrv_ff [gpio_pkg::PORT_COUNT];
  logic [7:0] stopr_ff[gpio_pkg::PORT_COUNT];
  logic [7:0] out_ff  [gpio_pkg::PORT_COUNT];
  logic [7:0] in_ff   [gpio_pkg::PORT_COUNT];
  logic [7:0] sync_lvl[gpio_pkg::PORT_COUNT];
  logic [7:0] sync_r  [gpio_pkg::PORT_COUNT];
  logic [7:0] sync_f  [gpio_pkg::PORT_COUNT];
  logic [7:0] irq_ff  [2];
  logic [63:0] pout_ff;
  logic [63:0] poe_ff;
  logic [2:0]  pidx;

  // decode of the subregister select; used for both writes and reads
  function automatic gpio_pkg::subreg_t decode_sel(input logic [7:0] s);
    case (s)
      gpio_pkg::SEL_DIR:   decode_sel = gpio_pkg::SUB_DIR;
      gpio_pkg::SEL_ALT:   decode_sel = gpio_pkg::SUB_ALT;
      gpio_pkg::SEL_ODRN:  decode_sel = gpio_pkg::SUB_ODRN;
      gpio_pkg::SEL_HDRV:  decode_sel = gpio_pkg::SUB_HDRV;
      gpio_pkg::SEL_STOPR: decode_sel = gpio_pkg::SUB_STOPR;
      default:             decode_sel = gpio_pkg::SUB_NONE;
    endcase
  endfunction

  // port h has only four pins; upper bits are held at zero
  function automatic logic [7:0] port_mask(input int p);
    port_mask = (p == gpio_pkg::PORT_H) ? 8'h0f : 8'hff; // R1
  endfunction

  assign pidx = port_sel_i[2:0];

  genvar g;
  generate
    for (g = 0; g < gpio_pkg::PORT_COUNT; g++) begin : g_port
      gpio_pin_sync u_sync (
        .clk_i   (clk_i),
        .srst_i  (srst_i),
        .pin_i   (pin_in_i[g*8 +: 8]),
        .level_o (sync_lvl[g]),
        .rise_o  (sync_r[g]),
        .fall_o  (sync_f[g])
      );

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          sel_ff[g] <= gpio_pkg::RST_SEL;
        end else if (sel_we_i && pidx == 3'(g)) begin
          sel_ff[g] <= sel_wdata_i;
        end
      end

      // whole-byte writes, but each bit steers only its own pin
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          dir_ff[g]   <= gpio_pkg::RST_DIR & port_mask(g);
          alt_ff[g]   <= gpio_pkg::RST_ZERO;
          odrn_ff[g]  <= gpio_pkg::RST_ZERO;
          hdrv_ff[g]  <= gpio_pkg::RST_ZERO;
          stopr_ff[g] <= gpio_pkg::RST_ZERO;
        end else if (ctl_we_i && pidx == 3'(g)) begin // R2 R3
          case (decode_sel(sel_ff[g])) // R13
            gpio_pkg::SUB_DIR:   dir_ff[g]   <= ctl_wdata_i & port_mask(g);
            gpio_pkg::SUB_ALT:   alt_ff[g]   <= ctl_wdata_i & port_mask(g);
            gpio_pkg::SUB_ODRN:  odrn_ff[g]  <= ctl_wdata_i & port_mask(g);
            gpio_pkg::SUB_HDRV:  hdrv_ff[g]  <= ctl_wdata_i & port_mask(g);
            gpio_pkg::SUB_STOPR: stopr_ff[g] <= ctl_wdata_i & port_mask(g);
            default:             ;
          endcase
        end
      end

      sel_none_a: assert property (@(posedge clk_i) disable iff (srst_i) // R13
        ctl_we_i && pidx == 3'(g) && decode_sel(sel_ff[g]) == gpio_pkg::SUB_NONE |=>
        $stable(dir_ff[g]) && $stable(alt_ff[g]) && $stable(odrn_ff[g]) &&
        $stable(hdrv_ff[g]) && $stable(stopr_ff[g]))
        else $error("control write leaked with null select");

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          out_ff[g] <= gpio_pkg::RST_ZERO;
        end else if (out_we_i && pidx == 3'(g)) begin
          out_ff[g] <= out_wdata_i & port_mask(g);
        end
      end

      // input register samples pins set as inputs or switched to alternate
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          in_ff[g] <= gpio_pkg::RST_ZERO;
        end else begin
          in_ff[g] <= ((sync_lvl[g] & (dir_ff[g] | alt_ff[g])) |
                       (in_ff[g] & ~(dir_ff[g] | alt_ff[g]))) & port_mask(g); // R12 R14
        end
      end

      for (genvar b = 0; b < 8; b++) begin : g_pin
        logic gp_oe;
        logic gp_dat;
        logic od;
        logic i2c;
        always_comb begin
          i2c = (g == gpio_pkg::PORT_A) &&
                (b == gpio_pkg::BIT_I2C_CLK || b == gpio_pkg::BIT_I2C_DAT);
          if (alt_ff[g][b]) begin // R4
            gp_oe  = periph_oe_i[g*8+b]; // R5
            gp_dat = periph_out_i[g*8+b];
            if (g == gpio_pkg::PORT_A && b == 1) gp_dat = timer0_out_alt_i; // R7
            if (g == gpio_pkg::PORT_C && b == 1) gp_dat = timer1_out_alt_i; // R8
            if (g == gpio_pkg::PORT_C && b == 7) gp_dat = timer2_out_alt_i; // R8
            if (g == gpio_pkg::PORT_D && b == 1) gp_dat = timer3_out_alt_i; // R9
            if (g == gpio_pkg::PORT_D && b == gpio_pkg::BIT_PD_NONE) gp_oe = 1'b0; // R9
          end else begin
            gp_oe  = ~dir_ff[g][b]; // R12
            gp_dat = out_ff[g][b];
          end
          od = odrn_ff[g][b] | (i2c & alt_ff[g][b]); // R6
          if (g == gpio_pkg::PORT_H && b >= gpio_pkg::PORT_H_W) gp_oe = 1'b0;
        end

        // open-drain only ever pulls low
        always_ff @(posedge clk_i) begin
          if (srst_i) begin
            pout_ff[g*8+b] <= 1'b0;
            poe_ff[g*8+b]  <= 1'b0;
          end else begin
            pout_ff[g*8+b] <= od ? 1'b0 : gp_dat;
            poe_ff[g*8+b]  <= gp_oe & ~(od & gp_dat);
          end
        end
        assign periph_in_o[g*8+b] = sync_lvl[g][b] & alt_ff[g][b];
      end
      assign pin_high_drive_o[g*8 +: 8]  = hdrv_ff[g];
      assign stop_recover_en_o[g*8 +: 8] = stopr_ff[g];
    end
  endgenerate

  assign pin_out_o = pout_ff;
  assign pin_oe_o  = poe_ff;

  // timer inputs: a0, c0, c6, d0 (pairs of in/out slots)
  assign timer_in_alt_o = {1'b0, periph_in_o[3*8+0], 1'b0, periph_in_o[2*8+6],
                           1'b0, periph_in_o[2*8+0], 1'b0, periph_in_o[0]}; // R7 R8 R9

  // events: port a pins selectable edge, port c pins any edge
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_ff[0] <= 8'h00;
      irq_ff[1] <= 8'h00;
    end else begin
      irq_ff[0] <= (edge_rise_sel_i & sync_r[gpio_pkg::PORT_A]) |
                   (~edge_rise_sel_i & sync_f[gpio_pkg::PORT_A]); // R10
      irq_ff[1] <= sync_r[gpio_pkg::PORT_C] | sync_f[gpio_pkg::PORT_C]; // R11
    end
  end
  assign pin_irq_o = {irq_ff[1], irq_ff[0]};

  always_comb begin
    sel_rdata_o = sel_ff[pidx];
    out_rdata_o = out_ff[pidx];
    in_rdata_o  = in_ff[pidx];
    case (decode_sel(sel_ff[pidx]))
      gpio_pkg::SUB_DIR:   ctl_rdata_o = dir_ff[pidx];
      gpio_pkg::SUB_ALT:   ctl_rdata_o = alt_ff[pidx];
      gpio_pkg::SUB_ODRN:  ctl_rdata_o = odrn_ff[pidx];
      gpio_pkg::SUB_HDRV:  ctl_rdata_o = hdrv_ff[pidx];
      gpio_pkg::SUB_STOPR: ctl_rdata_o = stopr_ff[pidx];
      default:             ctl_rdata_o = 8'h00;
    endcase
  end

  dir_out_a: assert property (@(posedge clk_i) disable iff (srst_i) // R12
    !alt_ff[gpio_pkg::PORT_A][0] && !dir_ff[gpio_pkg::PORT_A][0] &&
    !(odrn_ff[gpio_pkg::PORT_A][0] && out_ff[gpio_pkg::PORT_A][0]) |=> pin_oe_o[0])
    else $error("output direction not driving");
  dir_in_a: assert property (@(posedge clk_i) disable iff (srst_i) // R12
    !alt_ff[gpio_pkg::PORT_A][0] && dir_ff[gpio_pkg::PORT_A][0] |=> !pin_oe_o[0])
    else $error("input direction still driving");
  i2c_odrain_a: assert property (@(posedge clk_i) disable iff (srst_i) // R6
    alt_ff[gpio_pkg::PORT_A][6] |=> !(pin_oe_o[6] && pin_out_o[6]))
    else $error("i2c pin drove high");
  alt_dir_a: assert property (@(posedge clk_i) disable iff (srst_i) // R5
    alt_ff[gpio_pkg::PORT_C][3] && !odrn_ff[gpio_pkg::PORT_C][3] |=> pin_oe_o[19] == $past(periph_oe_i[19]))
    else $error("alternate pin ignored peripheral direction");
  port_h_a: assert property (@(posedge clk_i) disable iff (srst_i) // R1
    pin_oe_o[63:60] == 4'h0 && dir_ff[gpio_pkg::PORT_H][7:4] == 4'h0)
    else $error("missing port h bits active");
  // the first sample must lie outside reset: reset reloads the chain from the pin
  sequence rise_s; !srst_i && !sync_lvl[gpio_pkg::PORT_C][0] ##1 sync_lvl[gpio_pkg::PORT_C][0]; endsequence
  sequence fall_s; !srst_i && sync_lvl[gpio_pkg::PORT_C][0] ##1 !sync_lvl[gpio_pkg::PORT_C][0]; endsequence
  both_edge_a: assert property (@(posedge clk_i) disable iff (srst_i) // R11
    (rise_s or fall_s) |=> pin_irq_o[8])
    else $error("any-edge pin missed event");
  one_edge_a: assert property (@(posedge clk_i) disable iff (srst_i) // R10
    sync_r[gpio_pkg::PORT_A][2] && !edge_rise_sel_i[2] |=> !pin_irq_o[2])
    else $error("wrong edge raised event");
endmodule

// [verification/gpio_pin_env.sv]
// board model: pull-ups and an external driver on every pin
`timescale 1ns/1ps
module gpio_pin_env (
  input  wire logic [63:0] pin_out_i,
  input  wire logic [63:0] pin_oe_i,
  input  wire logic [63:0] ext_drive_i,
  input  wire logic [63:0] ext_val_i,
  output logic      [63:0] pin_in_o
);
  // an undriven pin settles at its pull-up, never at the last driven value
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (pin_oe_i[i]) pin_in_o[i] = pin_out_i[i];
      else if (ext_drive_i[i]) pin_in_o[i] = ext_val_i[i];
      else pin_in_o[i] = 1'b1;
    end
  end
endmodule

// [verification/tb_gpio_ports.sv]
// self-checking bench for the gpio port block
`timescale 1ns/1ps
module tb_gpio_ports;
  typedef struct packed {logic [7:0] p, s, d, e;} row_t;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [7:0]  port_sel_i = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic        sel_we = 1'b0;
  logic        ctl_we = 1'b0;
  logic        out_we = 1'b0;
  logic [7:0]  rise_sel = 8'hff;
  logic [3:0]  tmr = 4'h0;
  logic [63:0] p_out = 64'h0;
  logic [63:0] p_oe = 64'h0;
  logic [63:0] ext_val = 64'h0;
  logic [63:0] pin_in;
  logic [7:0]  sel_rd, ctl_rd, out_rd, in_rd, tin;
  logic [63:0] pin_out, pin_oe, hdrv, stopr, p_in;
  logic [15:0] irq;
  int          n_errors = 0;
  int          checks = 0;
  row_t        rows[8] = '{'{8'h00, 8'h01, 8'ha5, 8'ha5}, '{8'h02, 8'h02, 8'h3c, 8'h3c},
                           '{8'h03, 8'h03, 8'hf0, 8'hf0}, '{8'h04, 8'h04, 8'h81, 8'h81},
                           '{8'h05, 8'h05, 8'h7e, 8'h7e}, '{8'h06, 8'h00, 8'hff, 8'h00},
                           '{8'h01, 8'h06, 8'hff, 8'h00}, '{8'h07, 8'h01, 8'hf0, 8'h00}};

  gpio_ports DUT (.clk_i(clk_i), .srst_i(srst_i), .port_sel_i(port_sel_i), .sel_we_i(sel_we),
    .sel_wdata_i(wdata), .sel_rdata_o(sel_rd), .ctl_we_i(ctl_we), .ctl_wdata_i(wdata),
    .ctl_rdata_o(ctl_rd), .out_we_i(out_we), .out_wdata_i(wdata), .out_rdata_o(out_rd),
    .in_rdata_o(in_rd), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
    .pin_high_drive_o(hdrv), .stop_recover_en_o(stopr), .edge_rise_sel_i(rise_sel),
    .pin_irq_o(irq), .periph_out_i(p_out), .periph_oe_i(p_oe), .periph_in_o(p_in),
    .timer_in_alt_o(tin), .timer0_out_alt_i(tmr[0]), .timer1_out_alt_i(tmr[1]),
    .timer2_out_alt_i(tmr[2]), .timer3_out_alt_i(tmr[3]));
  gpio_pin_env env (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_drive_i(~64'h0),
    .ext_val_i(ext_val), .pin_in_o(pin_in));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic finish_test;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // k: 0 select, 1 control, 2 output data; strobe drops on the sampling edge
  task automatic wr(input logic [7:0] p, input logic [1:0] k, input logic [7:0] d);
    @(posedge clk_i);
    port_sel_i <= p;
    wdata      <= d;
    sel_we     <= (k == 2'h0);
    ctl_we     <= (k == 2'h1);
    out_we     <= (k == 2'h2);
    @(posedge clk_i);
    sel_we     <= 1'b0;
    ctl_we     <= 1'b0;
    out_we     <= 1'b0;
    #1;
  endtask

  task automatic cfg(input logic [7:0] p, s, d);
    wr(p, 2'h0, s);
    wr(p, 2'h1, d);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // checks the cycle of the single irq pulse against exp_at, 0 if none, 99 if repeated
  task automatic probe(input int pin, input int b, input logic v, input int exp_at);
    int at;
    at = 0;
    @(posedge clk_i);
    ext_val[pin] <= v;
    for (int i = 1; i <= 8; i++) begin
      settle(1);
      if (irq[b] === 1'b1) at = (at == 0) ? i : 99;
      else if (irq[b] !== 1'b0) at = 99;
    end
    chk("irq cycle", 64'(exp_at), 64'(at));
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    settle(1);
    chk("reset oe", 64'h0, pin_oe);
    chk("reset select", 64'h0, {56'h0, sel_rd});
    foreach (rows[i]) begin
      cfg(rows[i].p, rows[i].s, rows[i].d);
      chk("ctl readback", {56'h0, rows[i].e}, {56'h0, ctl_rd});
      chk("select readback", {56'h0, rows[i].s}, {56'h0, sel_rd});
    end
    settle(1);
    chk("high drive", 64'h0000_0081_0000_0000, hdrv);
    chk("stop recover", 64'h0000_7e00_0000_0000, stopr);
    chk("direction oe", 64'h0f5a, {48'h0, pin_oe[63:56], pin_oe[7:0]});
    probe(2, 2, 1'b1, 3);
    probe(2, 2, 1'b0, 0);
    @(posedge clk_i);
    rise_sel <= 8'h00;
    probe(2, 2, 1'b1, 0);
    probe(2, 2, 1'b0, 3);
    probe(16, 8, 1'b1, 3);
    probe(16, 8, 1'b0, 3);
    cfg(8'h00, 8'h01, 8'h00);
    wr(8'h00, 2'h2, 8'h5a);
    settle(1);
    chk("drive out", 64'hff5a5a, {40'h0, pin_oe[7:0], pin_out[7:0], out_rd});
    cfg(8'h00, 8'h03, 8'h0f);
    settle(1);
    chk("open drain", 64'hf5, {56'h0, pin_oe[7:0]});
    // alternate mode: the peripheral owns direction, a6/a7 release on high data
    @(posedge clk_i);
    p_oe    <= 64'h0000_0000_ffff_00fe;
    p_out   <= 64'h0000_0000_0033_00c0;
    tmr     <= 4'hc;
    ext_val <= 64'h1;
    cfg(8'h00, 8'h02, 8'hff);
    cfg(8'h02, 8'h02, 8'hff);
    cfg(8'h03, 8'h02, 8'hff);
    settle(4);
    chk("alt port a oe", 64'h3e, {56'h0, pin_oe[7:0]});
    chk("timer inputs", 64'h05, {56'h0, tin});
    chk("peripheral in", 64'h0000_0000_02b1_0001, p_in);
    chk("input data", 64'h02, {56'h0, in_rd});
    chk("alt port c", 64'hffb1, {48'h0, pin_oe[23:16], pin_out[23:16]});
    chk("alt port d", 64'hfb02, {48'h0, pin_oe[31:24], pin_out[31:24] & 8'hfb});
    // mid-run reset, held two edges so no property straddles its release
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    settle(1);
    chk("reset again oe", 64'h0, pin_oe);
    chk("reset again drive", 64'h0, hdrv | stopr);
    chk("reset again regs", 64'h0, {40'h0, sel_rd, out_rd, ctl_rd});
    finish_test();
  end
endmodule
